// file: hw/rra_top.sv
// Remote answer return engine for Receive command blocks
// Notes on behaviour
// (RULE_01) Answer returned as ASCII or binary format
// (RULE_02) Answer continues across successive Receive blocks
// (RULE_03) ASCII answer ends with asterisk
// (RULE_04) Host repeats Receive until asterisk arrives
// (RULE_05) Binary answer: 0x10 byte, length word
// (RULE_06) Leading codes 0x11 to 0x1f never emitted
// (RULE_07) Binary answer also ends with asterisk
// (RULE_08) Host sets completion notification bit
// (RULE_09) Host sets speed field to two
// (RULE_10) Page table bit clear or set accepted
// (RULE_11) Host page size zero unless page table
// (RULE_12) Host sets direction bit to one
// (RULE_13) Host sets maximum payload to nine
// (RULE_14) Host data size at least eighty bytes
// (RULE_15) Status block written to login status address
// (RULE_16) Bytes ascending, most significant first per quadlet
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module rra_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Receive command blocks
   input wire logic orb_valid,
   input rra_pkg::rra_orb_t orb,
   output logic orb_ready,
   // Answer bytes from the command processor
   input wire logic ans_valid,
   input wire logic [7:0] ans_byte,
   input wire logic ans_last,
   input wire logic ans_binary,
   input wire logic [23:0] ans_len,
   output logic ans_ready,
   // Host buffer writes
   output logic wr_valid,
   output rra_pkg::rra_word_t wr_word,
   input wire logic wr_ready,
   // Status block writes
   input wire logic [47:0] status_fifo_addr,
   output logic stat_valid,
   output rra_pkg::rra_stat_t stat,
   input wire logic stat_ready
);

   // ****************************************
   // State
   // ****************************************
   rra_pkg::rra_state_t st_q, st_d;
   rra_pkg::rra_phase_t ph_q, ph_d;
   logic en_q;
   logic [1:0] hidx_q;
   logic [31:0] hdr_q;
   logic first_q;
   logic [7:0] hold_q;
   logic hold_v_q, hold_v_d, hold_last_q;
   logic [15:0] budget_q, size_q;
   logic [31:0] waddr_q;
   logic term_q;
   logic [31:0] orbs_q, bytes_q;

   // ****************************************
   // Decode
   // ****************************************
   wire wr_ctrl = reg_wr && reg_addr == rra_pkg::REG_CTRL;
   wire orb_take = orb_valid && orb_ready; // RULE_10
   // Abort yields to a block taken in the same cycle, else RUN has no phase
   wire abort = wr_ctrl && reg_wdata[rra_pkg::CTRL_ABORT_BIT]
      && st_q == rra_pkg::ST_IDLE && !orb_take;
   wire take = ans_valid && ans_ready;
   wire run = st_q == rra_pkg::ST_RUN;
   wire in_hdr = ph_q == rra_pkg::PH_HDR;
   wire in_body = ph_q == rra_pkg::PH_BODY;
   wire in_term = ph_q == rra_pkg::PH_TERM;
   wire [7:0] hdr_byte = hdr_q[31 - 8*hidx_q -: 8];
   wire rsv_lead = first_q && hold_q >= rra_pkg::FMT_BINARY
      && hold_q <= rra_pkg::FMT_RSV_HI;
   wire [7:0] body_byte = rsv_lead ? rra_pkg::ASCII_FILL : hold_q; // RULE_06
   wire [7:0] cur_byte = in_hdr ? hdr_byte :
      in_term ? rra_pkg::ASCII_TERM : body_byte; // RULE_03 RULE_07
   wire avail = in_hdr || in_term || (in_body && hold_v_q);
   wire pk_ready, pk_idle, pk_valid, bf_ready;
   rra_pkg::rra_word_t pk_word;
   wire emit = run && avail && pk_ready && budget_q != 16'h0000;
   wire consume = emit && in_body;
   wire done_term = emit && in_term;
   wire pk_push = pk_valid && bf_ready;
   wire drained = pk_idle && !wr_valid;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         rra_pkg::ST_IDLE: begin
            if (orb_take) begin
               st_d = rra_pkg::ST_RUN;
            end
         end
         rra_pkg::ST_RUN: begin
            if (budget_q == 16'h0000 || done_term) begin
               st_d = rra_pkg::ST_FLUSH; // RULE_02
            end
         end
         rra_pkg::ST_FLUSH: begin
            if (drained) begin
               st_d = rra_pkg::ST_STAT;
            end
         end
         rra_pkg::ST_STAT: begin
            if (stat_valid && stat_ready) begin
               st_d = rra_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      ph_d = ph_q;
      if (abort) begin
         ph_d = rra_pkg::PH_NONE;
      end else if (orb_take && ph_q == rra_pkg::PH_NONE) begin
         ph_d = ans_binary ? rra_pkg::PH_HDR
            : rra_pkg::PH_BODY; // RULE_01
      end else if (emit && in_hdr && hidx_q == rra_pkg::HDR_LAST) begin
         ph_d = rra_pkg::PH_BODY; // RULE_05
      end else if (consume && hold_last_q) begin
         ph_d = rra_pkg::PH_TERM;
      end else if (done_term) begin
         ph_d = rra_pkg::PH_NONE;
      end
   end

   always_comb begin
      hold_v_d = hold_v_q;
      if (take) begin
         hold_v_d = 1'b1;
      end else if (consume || abort) begin
         hold_v_d = 1'b0;
      end
   end

   // ****************************************
   // Answer sequencing
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= rra_pkg::ST_IDLE;
         ph_q <= rra_pkg::PH_NONE;
         hidx_q <= 2'h0;
         hdr_q <= 32'h0000_0000;
         first_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         if (orb_take && ph_q == rra_pkg::PH_NONE) begin
            hidx_q <= 2'h0;
            hdr_q <= {rra_pkg::FMT_BINARY, ans_len}; // RULE_05
            first_q <= !ans_binary;
         end else if (emit && in_hdr) begin
            hidx_q <= hidx_q + 2'h1;
         end
         if (consume) begin
            first_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= 8'h00;
         hold_last_q <= 1'b0;
         hold_v_q <= 1'b0;
         ans_ready <= 1'b0;
      end else begin
         if (take) begin
            hold_q <= ans_byte;
            hold_last_q <= ans_last;
         end
         hold_v_q <= hold_v_d;
         ans_ready <= !hold_v_d;
      end
   end

   // ****************************************
   // Buffer window of the current block
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         budget_q <= 16'h0000;
         size_q <= 16'h0000;
         waddr_q <= 32'h0000_0000;
         term_q <= 1'b0;
         orb_ready <= 1'b0;
      end else begin
         orb_ready <= st_d == rra_pkg::ST_IDLE && en_q && !orb_take;
         if (orb_take) begin
            budget_q <= orb.data_size;
            size_q <= orb.data_size;
            waddr_q <= orb.data_descriptor;
            term_q <= 1'b0;
         end else begin
            if (emit) begin
               budget_q <= budget_q - 16'h0001;
            end
            if (pk_push) begin
               waddr_q <= waddr_q + 32'h0000_0004; // RULE_16
            end
            if (done_term) begin
               term_q <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Status block
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stat_valid <= 1'b0;
         stat <= '0;
      end else begin
         if (st_q == rra_pkg::ST_FLUSH && drained) begin
            stat_valid <= 1'b1; // RULE_15
            stat <= '{fifo_addr: status_fifo_addr,
               resp: rra_pkg::RESP_OK, term: term_q,
               len: size_q - budget_q};
         end else if (stat_ready) begin
            stat_valid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   wire [31:0] stat_word = {28'h000_0000, term_q,
      ph_q != rra_pkg::PH_NONE, hold_v_q, st_q != rra_pkg::ST_IDLE};
   wire [31:0] rd_mux =
      reg_addr == rra_pkg::REG_CTRL ? {31'h0, en_q} :
      reg_addr == rra_pkg::REG_STAT ? stat_word :
      reg_addr == rra_pkg::REG_ORBS ? orbs_q :
      reg_addr == rra_pkg::REG_BYTES ? bytes_q : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         en_q <= rra_pkg::CTRL_EN_RST;
         orbs_q <= 32'h0000_0000;
         bytes_q <= 32'h0000_0000;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            en_q <= reg_wdata[rra_pkg::CTRL_EN_BIT];
         end
         if (stat_valid && stat_ready) begin
            orbs_q <= orbs_q + 32'h0000_0001;
         end
         if (emit) begin
            bytes_q <= bytes_q + 32'h0000_0001;
         end
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // ****************************************
   // Datapath
   // ****************************************
   rra_pack u_pack (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(emit),
      .in_byte(cur_byte),
      .flush(st_q == rra_pkg::ST_FLUSH),
      .word_addr(waddr_q),
      .in_ready(pk_ready),
      .idle(pk_idle),
      .out_valid(pk_valid),
      .out_word(pk_word),
      .out_ready(bf_ready)
   );

   rra_buf2 u_buf (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(pk_valid),
      .in_word(pk_word),
      .in_ready(bf_ready),
      .out_valid(wr_valid),
      .out_word(wr_word),
      .out_ready(wr_ready)
   );

endmodule // rra_top

// file: shared/rra_pkg.sv
// Constants and types shared by the answer return engine
package rra_pkg;

   // ****************************************
   // Answer format bytes
   // ****************************************
   localparam logic [7:0] FMT_BINARY = 8'h10;
   localparam logic [7:0] FMT_RSV_LO = 8'h11;
   localparam logic [7:0] FMT_RSV_HI = 8'h1f;
   localparam logic [7:0] ASCII_TERM = 8'h2a;
   localparam logic [7:0] ASCII_FILL = 8'h20;
   localparam logic [1:0] HDR_LAST = 2'h3;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_ORBS = 8'h08;
   localparam logic [7:0] REG_BYTES = 8'h0c;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam logic CTRL_EN_RST = 1'h1;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [3:0] BE_NONE = 4'h0;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic n;
      logic [1:0] request_format_field;
      logic dir;
      logic [2:0] spd;
      logic [3:0] max_payload;
      logic p;
      logic [2:0] page_size;
      logic [15:0] data_size;
      logic [31:0] data_descriptor;
   } rra_orb_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be;
   } rra_word_t;

   typedef struct packed {
      logic [47:0] fifo_addr;
      logic [1:0] resp;
      logic term;
      logic [15:0] len;
   } rra_stat_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN = 4'h2,
      ST_FLUSH = 4'h4,
      ST_STAT = 4'h8
   } rra_state_t;

   typedef enum logic [3:0] {
      PH_NONE = 4'h1,
      PH_HDR = 4'h2,
      PH_BODY = 4'h4,
      PH_TERM = 4'h8
   } rra_phase_t;

endpackage

// file: hw/rra_buf2.sv
// Two-entry buffer for host buffer quadlet writes
`timescale 1ns/1ns
module rra_buf2 (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   input rra_pkg::rra_word_t in_word,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output rra_pkg::rra_word_t out_word,
   input wire logic out_ready
);
   rra_pkg::rra_word_t ent_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q, cnt_d;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   assign out_word = ent_q[rp_q];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         ent_q[wp_q] <= in_word;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wp_q <= wp_q ^ push;
         rp_q <= rp_q ^ pop;
         cnt_q <= cnt_d;
         in_ready <= cnt_d != 2'h2;
         out_valid <= cnt_d != 2'h0;
      end
   end
endmodule // rra_buf2

// file: hw/rra_pack.sv
// Byte to quadlet packer, most significant byte first
`timescale 1ns/1ns
module rra_pack (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Byte side
   input wire logic in_valid,
   input wire logic [7:0] in_byte,
   input wire logic flush,
   input wire logic [31:0] word_addr,
   output logic in_ready,
   output logic idle,
   // Quadlet side
   output logic out_valid,
   output rra_pkg::rra_word_t out_word,
   input wire logic out_ready
);
   logic [1:0] cnt_q;
   logic [31:0] data_q;
   logic [3:0] be_q;
   wire take = in_valid && in_ready;
   wire full = take && (cnt_q == rra_pkg::HDR_LAST);
   wire part = flush && !out_valid && (cnt_q != 2'h0);

   assign in_ready = !out_valid;
   assign idle = !out_valid && (cnt_q == 2'h0);
   assign out_word = '{addr: word_addr, data: data_q, be: be_q};

   // ****************************************
   // Byte lanes, lane 0 in bits 31:24
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_lane
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               data_q[31-8*i -: 8] <= 8'h00;
               be_q[3-i] <= 1'b0;
            end else if (take && cnt_q == 2'(i)) begin
               data_q[31-8*i -: 8] <= in_byte; // RULE_16
               be_q[3-i] <= 1'b1;
            end else if (out_valid && out_ready) begin
               data_q[31-8*i -: 8] <= 8'h00;
               be_q[3-i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 2'h0;
         out_valid <= 1'b0;
      end else begin
         if (take) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (part) begin
            cnt_q <= 2'h0;
         end
         if (full || part) begin
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // rra_pack

// file: tb/rra_chk.sv
// Port checks for the answer return engine
`timescale 1ns/1ns
module rra_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Register port
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Command blocks
   input wire logic orb_valid,
   input wire logic orb_ready,
   // Host buffer writes
   input wire logic wr_valid,
   input rra_pkg::rra_word_t wr_word,
   input wire logic wr_ready,
   // Status block writes
   input wire logic [47:0] status_fifo_addr,
   input wire logic stat_valid,
   input rra_pkg::rra_stat_t stat,
   input wire logic stat_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // Assertions
   // ****************************************
   chk_rdata_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   chk_orb_take_drop: assert property (orb_valid && orb_ready |=> !orb_ready)
      else $error("command ready stayed after take");
   chk_wr_hold: assert property (wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_word)) else $error("write changed while stalled");
   chk_stat_hold: assert property (stat_valid && !stat_ready |=>
      stat_valid && $stable(stat)) else $error("status changed while stalled");
   chk_stat_fifo: assert property (stat_valid |->
      stat.fifo_addr == status_fifo_addr) else $error("status address wrong");
   chk_stat_drained: assert property (stat_valid |-> !wr_valid)
      else $error("status before writes drained");
   chk_stat_resp: assert property (stat_valid |-> stat.resp == rra_pkg::RESP_OK)
      else $error("status response not ok");
   chk_wr_lanes: assert property (wr_valid |->
      wr_word.be != rra_pkg::BE_NONE && wr_word.addr[1:0] == 2'h0)
      else $error("write lanes or alignment wrong");
   chk_busy_no_orb: assert property (stat_valid || wr_valid |-> !orb_ready)
      else $error("command ready while busy");
   cover property (stat_valid && stat_ready && stat.term);
   cover property (stat_valid && stat_ready && !stat.term);
   cover property (wr_valid && !wr_ready);
endmodule // rra_chk

// file: tb/rra_host_model.sv
// Host initiator model issuing Receive blocks and sinking writes
`timescale 1ns/1ns
module rra_host_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command blocks
   output logic orb_valid,
   output rra_pkg::rra_orb_t orb,
   input wire logic orb_ready,
   // Host buffer and status sinks
   input wire logic wr_valid,
   input rra_pkg::rra_word_t wr_word,
   output logic wr_ready,
   input wire logic stat_valid,
   input rra_pkg::rra_stat_t stat,
   output logic stat_ready,
   // Stall control
   input wire logic stall
);
   rra_pkg::rra_word_t words[$];
   rra_pkg::rra_stat_t last_stat;
   logic [3:0] cyc_q;
   int n_stat;
   initial begin
      orb_valid = 1'b0;
      orb = '0;
      wr_ready = 1'b0;
      stat_ready = 1'b0;
      cyc_q = 4'h0;
      n_stat = 0;
   end
   // Slow sinks: stall lets one write through in eight cycles
   always @(posedge ref_clk) begin
      cyc_q <= cyc_q + 4'h1;
      wr_ready <= rstn && (!stall || cyc_q[2:0] == 3'h7);
      stat_ready <= rstn && stat_valid && !stat_ready;
      if (wr_valid && wr_ready) words.push_back(wr_word);
      if (stat_valid && stat_ready) begin
         last_stat <= stat;
         n_stat <= n_stat + 1;
      end
   end
   // One Receive block, returns after its status arrives
   task automatic issue(input logic [31:0] base, input logic pbit);
      int n0;
      n0 = n_stat;
      orb.n <= 1'b1;
      orb.request_format_field <= 2'h0;
      orb.dir <= 1'b1;
      orb.spd <= 3'h2;
      orb.max_payload <= 4'h9;
      orb.p <= pbit;
      orb.page_size <= pbit ? 3'h1 : 3'h0;
      orb.data_size <= 16'h50;
      orb.data_descriptor <= base;
      orb_valid <= 1'b1;
      @(posedge ref_clk);
      while (!orb_ready) @(posedge ref_clk);
      orb_valid <= 1'b0;
      while (n_stat == n0) @(posedge ref_clk);
   endtask
endmodule // rra_host_model

// file: tb/rra_bench.sv
// Self-checking bench for the answer return engine
`timescale 1ns/1ns
module rra_bench;
   logic ref_clk, rstn, reg_wr, reg_rd, orb_valid, orb_ready, stall;
   logic ans_valid, ans_last, ans_binary, ans_ready, bin_v;
   logic wr_valid, wr_ready, stat_valid, stat_ready;
   logic [7:0] reg_addr, ans_byte;
   logic [31:0] reg_wdata, reg_rdata;
   logic [23:0] ans_len, len_v;
   logic [47:0] status_fifo_addr;
   rra_pkg::rra_orb_t orb;
   rra_pkg::rra_word_t wr_word;
   rra_pkg::rra_stat_t stat;
   logic [7:0] src[$], nxt[$], exp_q[$];
   int src_i, n_cyc, num_errors, n_compared;
   rra_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .orb_valid(orb_valid), .orb(orb),
      .orb_ready(orb_ready), .ans_valid(ans_valid), .ans_byte(ans_byte),
      .ans_last(ans_last), .ans_binary(ans_binary), .ans_len(ans_len),
      .ans_ready(ans_ready), .wr_valid(wr_valid), .wr_word(wr_word),
      .wr_ready(wr_ready), .status_fifo_addr(status_fifo_addr),
      .stat_valid(stat_valid), .stat(stat), .stat_ready(stat_ready));
   rra_host_model u_host (.ref_clk(ref_clk), .rstn(rstn),
      .orb_valid(orb_valid), .orb(orb), .orb_ready(orb_ready),
      .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
      .stat_valid(stat_valid), .stat(stat), .stat_ready(stat_ready),
      .stall(stall));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Answer byte source standing in for the command processor
   always @(posedge ref_clk) begin
      if (ans_valid && ans_ready) src_i = src_i + 1;
      ans_valid <= rstn && src_i < src.size();
      ans_byte <= (src_i < src.size()) ? src[src_i] : ~ans_byte;
      ans_last <= (src_i == src.size() - 1);
      ans_binary <= bin_v;
      ans_len <= len_v;
   end
   always @(posedge ref_clk) begin
      n_cyc = n_cyc + 1;
      if (n_cyc == 20000) begin
         num_errors = num_errors + 1;
         final_report;
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared = n_compared + 1;
      if (seen !== want) begin
         num_errors = num_errors + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
      @(posedge ref_clk);
   endtask
   task automatic feed(input logic bin, input logic [23:0] len);
      @(negedge ref_clk);
      src = nxt;
      src_i = 0;
      bin_v = bin;
      len_v = len;
      @(posedge ref_clk);
   endtask
   task automatic check_block(input logic [31:0] base, input int from,
      input int cnt);
      rra_pkg::rra_word_t w;
      logic [31:0] d;
      logic [3:0] be;
      for (int i = 0; i < (cnt + 3) / 4; i++) begin
         d = 32'h0;
         be = 4'h0;
         for (int j = 0; j < 4; j++) begin
            if (4 * i + j < cnt) begin
               d[31 - 8 * j -: 8] = exp_q[from + 4 * i + j];
               be[3 - j] = 1'b1;
            end
         end
         w = u_host.words.pop_front();
         check(w.addr, base + 32'(4 * i));
         check(w.data, d);
         check({28'h0, w.be}, {28'h0, be});
      end
      check(32'(u_host.words.size()), 32'h0);
   endtask
   task automatic check_stat(input logic [15:0] len, input logic term);
      check({16'h0, u_host.last_stat.len}, {16'h0, len});
      check({31'h0, u_host.last_stat.term}, {31'h0, term});
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_regs;
      logic [31:0] d;
      reg_read(rra_pkg::REG_CTRL, d);
      check(d, 32'h1);
      reg_read(8'h40, d);
      check(d, 32'h0);
      reg_write(rra_pkg::REG_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk);
      check({31'h0, orb_ready}, 32'h0);
      reg_write(rra_pkg::REG_CTRL, 32'h1);
   endtask
   task automatic sc_ascii;
      nxt = '{8'h41, 8'h42};
      exp_q = '{8'h41, 8'h42, rra_pkg::ASCII_TERM};
      feed(1'b0, 24'h0);
      u_host.issue(32'h1000, 1'b0);
      check_block(32'h1000, 0, 3);
      check_stat(16'h3, 1'b1);
   endtask
   task automatic sc_binary;
      nxt = '{8'h00, 8'h11, 8'hff};
      exp_q = '{rra_pkg::FMT_BINARY, 8'h00, 8'h00, 8'h03, 8'h00, 8'h11,
         8'hff, rra_pkg::ASCII_TERM};
      stall <= 1'b1;
      feed(1'b1, 24'h3);
      u_host.issue(32'h2000, 1'b1);
      check_block(32'h2000, 0, 8);
      check_stat(16'h8, 1'b1);
      stall <= 1'b0;
   endtask
   task automatic sc_reserved;
      nxt = '{8'h15, 8'h41};
      exp_q = '{rra_pkg::ASCII_FILL, 8'h41, rra_pkg::ASCII_TERM};
      feed(1'b0, 24'h0);
      u_host.issue(32'h3000, 1'b1);
      check_block(32'h3000, 0, 3);
   endtask
   task automatic sc_split;
      nxt.delete();
      for (int i = 0; i < 82; i++) nxt.push_back(8'h41 + 8'(i % 26));
      exp_q = nxt;
      exp_q.push_back(rra_pkg::ASCII_TERM);
      feed(1'b0, 24'h0);
      u_host.issue(32'h4000, 1'b1);
      check_block(32'h4000, 0, 80);
      check_stat(16'h50, 1'b0);
      u_host.issue(32'h5000, 1'b0);
      check_block(32'h5000, 80, 3);
      check_stat(16'h3, 1'b1);
   endtask
   task automatic sc_abort;
      logic [31:0] d;
      nxt = '{8'h51, 8'h52};
      exp_q = '{8'h52, rra_pkg::ASCII_TERM};
      feed(1'b0, 24'h0);
      repeat (2) @(posedge ref_clk);
      reg_read(rra_pkg::REG_STAT, d);
      check(d, 32'ha);
      reg_write(rra_pkg::REG_CTRL, 32'h3);
      u_host.issue(32'h6000, 1'b0);
      check_block(32'h6000, 0, 2);
      check_stat(16'h2, 1'b1);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      rstn = 1'b0;
      {reg_wr, reg_rd, stall, bin_v} = 4'h0;
      {ans_valid, ans_last, ans_binary} = 3'h0;
      reg_addr = 8'h00;
      ans_byte = 8'h00;
      reg_wdata = 32'h0;
      {ans_len, len_v} = 48'h0;
      status_fifo_addr = 48'h0000_fffe_1000;
      {src_i, n_cyc, num_errors, n_compared} = 128'h0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sc_regs;
      sc_ascii;
      sc_binary;
      sc_reserved;
      sc_split;
      sc_abort;
      reg_read(rra_pkg::REG_ORBS, d);
      check(d, 32'h6);
      reg_read(rra_pkg::REG_BYTES, d);
      check(d, 32'h63);
      final_report;
   end
endmodule // rra_bench
bind rra_top rra_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .orb_valid(orb_valid), .orb_ready(orb_ready),
   .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
   .status_fifo_addr(status_fifo_addr), .stat_valid(stat_valid),
   .stat(stat), .stat_ready(stat_ready));
